// file: conv_asserts.sv
// Pin checks between the converter control end and its host end.
`timescale 1ns/1ns
`default_nettype none
module conv_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic convert_start_n,
    input wire logic power_down_request,
    input wire logic bandgap_powerdown_sel,
    input wire logic refbuffer_powerdown_sel,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic read_enable_n,
    input wire logic busy,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic result_unreliable
);
    import conv_pkg::*;
    // ***********************
    // Run counters
    // ***********************
    // Counters, since repetitions of 89 or 125 would choke the tools
    logic [7:0] busy_run_reg;
    logic [7:0] low_run_reg;
    logic [7:0] rst_run_reg;
    logic live_reg;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_run_reg <= 8'h00;
            low_run_reg <= 8'h00;
            rst_run_reg <= 8'h00;
            live_reg <= 1'b0;
        end else begin
            busy_run_reg <= busy ? busy_run_reg + 8'h01 : 8'h00;
            low_run_reg <= convert_start_n ? 8'h00 : low_run_reg + 8'h01;
            rst_run_reg <= reset ? rst_run_reg + 8'h01 : 8'h00;
            live_reg <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    // First edge after release still shows reset values
    default disable iff (!rst_b_i || !live_reg);
    start_launch_a: assert property ($fell(convert_start_n) && !busy && !power_down_request && !reset
        && !$past(reset) |=> busy) else $error("start edge did not raise busy");
    busy_length_a: assert property ($fell(busy) && !reset
        |-> busy_run_reg == CONV_CYCLES || busy_run_reg == INIT_CYCLES) else $error("busy run has wrong length");
    reset_abort_a: assert property (reset |=> !busy && !data_oe) else $error("reset did not abort");
    reset_init_a: assert property ($fell(reset) |=> busy && data_out == 16'h0000 && !result_unreliable)
        else $error("reset fall did not start init");
    data_hold_a: assert property (busy && $past(busy) && !reset |-> $stable(data_out))
        else $error("data changed while busy");
    readout_on_a: assert property (!reset && !chip_select_n && !read_enable_n ##1 !reset |-> data_oe)
        else $error("readout not driving");
    pd_reload_a: assert property ($fell(power_down_request) && !busy |=> result_unreliable)
        else $error("power-down exit not flagged");
    pd_block_a: assert property (power_down_request && $fell(convert_start_n) && !busy && !reset
        && !$past(reset) |=> !busy) else $error("start accepted in power-down");
    start_width_a: assert property ($rose(convert_start_n) |-> low_run_reg <= START_LOW_CYCLES)
        else $error("start held low too long");
    reset_width_a: assert property ($fell(reset) |-> rst_run_reg == RESET_PULSE_CYCLES)
        else $error("reset pulse wrong width");
    cover property ($fell(busy) && busy_run_reg == CONV_CYCLES);
    cover property ($fell(busy) && busy_run_reg == INIT_CYCLES);
    cover property ($fell(power_down_request));
    cover property (bandgap_powerdown_sel && refbuffer_powerdown_sel);
    cover property ($fell(convert_start_n) && chip_select_n);
endmodule
`default_nettype wire

// file: conv_device.sv
// Converter control end: conversion, reset initialization, power and reference state.
`timescale 1ns/1ns
`default_nettype none
module conv_device #(
    parameter int unsigned DISCARD = conv_pkg::DISCARD_COUNT
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    conv_if.device pins,
    input wire logic [15:0] sample_i,
    output logic core_low_power_o,
    output logic bandgap_enable_o,
    output logic buffer_enable_o,
    output conv_pkg::ref_mode_t ref_mode_o,
    output logic [15:0] conv_count_o
);
    import conv_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_RESET_HOLD, ST_INIT} dev_state_t;
    typedef struct packed {
        dev_state_t state;
        logic start_n_d;
        logic reset_d;
        logic pd_d;
        logic [CNT_W-1:0] timer;
        logic [CNT_W-1:0] discard_left;
        logic [15:0] result;
        logic busy;
        logic low_power;
        logic oe;
        logic bg_en;
        logic buf_en;
        ref_mode_t mode;
        logic [15:0] count;
    } dev_t;

    dev_t cur_reg;
    dev_t cur_next;
    ref_mode_t mode_w;
    logic bg_w;
    logic buf_w;

    ref_select u_ref (
        .bandgap_powerdown_sel_i(pins.bandgap_powerdown_sel),
        .refbuffer_powerdown_sel_i(pins.refbuffer_powerdown_sel),
        .ref_mode_o(mode_w),
        .bandgap_enable_o(bg_w),
        .buffer_enable_o(buf_w)
    );

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        logic start_fall;
        logic reset_rise;
        logic reset_fall;
        start_fall = 1'b0;
        reset_rise = 1'b0;
        reset_fall = 1'b0;
        cur_next = cur_reg;
        // Chip-select and read-enable enter only the readout enable below, never start or state logic
        start_fall = cur_reg.start_n_d & ~pins.convert_start_n;
        reset_rise = ~cur_reg.reset_d & pins.reset;
        reset_fall = cur_reg.reset_d & ~pins.reset;
        cur_next.start_n_d = pins.convert_start_n;
        cur_next.reset_d = pins.reset;
        cur_next.pd_d = pins.power_down_request;
        cur_next.bg_en = bg_w;
        cur_next.buf_en = buf_w;
        cur_next.mode = mode_w;
        // Readout driven whenever both selects low and reset low, in any phase
        cur_next.oe = ~pins.chip_select_n & ~pins.read_enable_n & ~pins.reset;
        if (cur_reg.pd_d & ~pins.power_down_request) begin
            cur_next.discard_left = CNT_W'(DISCARD);
        end
        case (cur_reg.state)
            ST_IDLE: begin
                cur_next.busy = 1'b0;
                cur_next.low_power = 1'b1;
                if (reset_rise) begin
                    cur_next.state = ST_RESET_HOLD;
                end else if (start_fall & ~pins.power_down_request) begin
                    cur_next.state = ST_CONVERT;
                    cur_next.timer = CNT_W'(CONV_CYCLES);
                    cur_next.busy = 1'b1;
                    cur_next.low_power = 1'b0;
                end
            end
            ST_CONVERT: begin
                // Power-down and further start edges have no effect here
                cur_next.timer = cur_reg.timer - CNT_ONE;
                if (reset_rise) begin
                    cur_next.state = ST_RESET_HOLD;
                    cur_next.busy = 1'b0;
                end else if (cur_reg.timer == CNT_ONE) begin
                    cur_next.state = ST_IDLE;
                    cur_next.result = sample_i;
                    cur_next.busy = 1'b0;
                    cur_next.low_power = 1'b1;
                    cur_next.count = cur_reg.count + 16'h0001;
                    if (cur_reg.discard_left != CNT_ZERO) begin
                        cur_next.discard_left = cur_reg.discard_left - CNT_ONE;
                    end
                end
            end
            ST_RESET_HOLD: begin
                cur_next.busy = 1'b0;
                if (reset_fall) begin
                    cur_next.state = ST_INIT;
                    cur_next.result = 16'h0000;
                    cur_next.timer = CNT_W'(INIT_CYCLES);
                    cur_next.busy = 1'b1;
                    cur_next.discard_left = CNT_ZERO;
                end
            end
            ST_INIT: begin
                cur_next.timer = cur_reg.timer - CNT_ONE;
                if (reset_rise) begin
                    cur_next.state = ST_RESET_HOLD;
                    cur_next.busy = 1'b0;
                end else if (cur_reg.timer == CNT_ONE) begin
                    cur_next.state = ST_IDLE;
                    cur_next.busy = 1'b0;
                end
            end
            default: begin
                cur_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_reg <= '{state: ST_IDLE, start_n_d: 1'b1, reset_d: 1'b0, pd_d: 1'b0, timer: CNT_ZERO,
                         discard_left: CNT_W'(DISCARD_COUNT), result: 16'h0000, busy: 1'b0,
                         low_power: 1'b1, oe: 1'b0, bg_en: 1'b0, buf_en: 1'b0, mode: REF_INVALID,
                         count: 16'h0000};
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign pins.busy = cur_reg.busy;
    assign pins.data_out = cur_reg.result;
    assign pins.data_oe = cur_reg.oe;
    assign pins.result_unreliable = (cur_reg.discard_left != CNT_ZERO);
    assign core_low_power_o = cur_reg.low_power;
    assign bandgap_enable_o = cur_reg.bg_en;
    assign buffer_enable_o = cur_reg.buf_en;
    assign ref_mode_o = cur_reg.mode;
    assign conv_count_o = cur_reg.count;
endmodule
`default_nettype wire

// file: conv_host.sv
// Host end: drives start, power and reference pins from software registers.
`timescale 1ns/1ns
`default_nettype none
module conv_host (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    conv_if.host pins,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    import conv_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic start_n;
        logic [CNT_W-1:0] low_cnt;
        logic pd;
        logic bgpd;
        logic bufpd;
        logic rst;
        logic [CNT_W-1:0] rst_cnt;
        logic autorun;
        logic csn;
        logic rdn;
        logic pending;
        logic unrel_d;
        logic [31:0] period;
        logic [31:0] tick;
        logic busy_d;
        logic [15:0] data;
        logic [15:0] good;
        logic [31:0] rdata;
    } host_t;

    host_t h_reg;
    host_t h_next;

    always_comb begin
        logic launch;
        launch = 1'b0;
        h_next = h_reg;
        h_next.busy_d = pins.busy;
        h_next.unrel_d = pins.result_unreliable;
        h_next.rdata = 32'h00000000;
        if (h_reg.autorun) begin
            h_next.tick = h_reg.tick + 32'h00000001;
            if (h_reg.tick >= h_reg.period) begin
                h_next.tick = 32'h00000000;
                launch = 1'b1;
            end
        end
        if (wr_i && addr_i == ADDR_CTRL) begin
            launch = launch | wdata_i[CTRL_START];
            h_next.pd = wdata_i[CTRL_PD];
            h_next.bgpd = wdata_i[CTRL_BGPD];
            h_next.bufpd = wdata_i[CTRL_BUFPD];
            h_next.autorun = wdata_i[CTRL_AUTO];
            h_next.csn = wdata_i[CTRL_CSN];
            h_next.rdn = wdata_i[CTRL_RDN];
            if (wdata_i[CTRL_RESET]) begin
                h_next.rst = 1'b1;
                h_next.pending = 1'b0;
                h_next.rst_cnt = CNT_W'(RESET_PULSE_CYCLES);
            end
        end
        if (wr_i && addr_i == ADDR_PERIOD) begin
            h_next.period = wdata_i;
        end
        // Start edges from a clean register: low jitter on the system clock
        if (launch && h_reg.start_n) begin
            h_next.start_n = 1'b0;
            h_next.low_cnt = CNT_W'(START_LOW_CYCLES);
        end else if (!h_reg.start_n) begin
            h_next.low_cnt = h_reg.low_cnt - CNT_ONE;
            if (h_reg.low_cnt == CNT_ONE) begin
                h_next.start_n = 1'b1;
            end
        end
        if (h_reg.rst) begin
            h_next.rst_cnt = h_reg.rst_cnt - CNT_ONE;
            if (h_reg.rst_cnt == CNT_ONE) begin
                h_next.rst = 1'b0;
            end
        end
        // Init busy pulse is no result; only launched conversions count
        if (h_reg.busy_d && !pins.busy && h_reg.pending) begin
            h_next.pending = 1'b0;
            h_next.data = pins.data_out;
            // Flag as it stood during the conversion; it clears with the last discarded code
            if (!h_reg.unrel_d) begin
                h_next.good = h_reg.good + 16'h0001;
            end
        end
        if (launch && h_reg.start_n && !pins.busy && !h_next.rst && !h_next.pd) begin
            h_next.pending = 1'b1;
        end
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: h_next.rdata = {24'h0, h_reg.rdn, h_reg.csn, h_reg.autorun, h_reg.rst, h_reg.bufpd,
                                           h_reg.bgpd, h_reg.pd, ~h_reg.start_n};
                ADDR_STATUS: h_next.rdata = {30'h0, pins.result_unreliable, pins.busy};
                ADDR_DATA: h_next.rdata = {16'h0, h_reg.data};
                ADDR_PERIOD: h_next.rdata = h_reg.period;
                ADDR_COUNT: h_next.rdata = {16'h0, h_reg.good};
                default: h_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            h_reg <= '{start_n: 1'b1, low_cnt: CNT_ZERO, pd: 1'b0, bgpd: 1'b0, bufpd: 1'b0, rst: 1'b0,
                       rst_cnt: CNT_ZERO, autorun: 1'b0, period: PERIOD_RESET, tick: 32'h00000000,
                       busy_d: 1'b0, data: 16'h0000, good: 16'h0000, rdata: 32'h00000000, csn: 1'b0, rdn: 1'b0,
                       pending: 1'b0, unrel_d: 1'b0};
        end else begin
            h_reg <= h_next;
        end
    end

    assign pins.convert_start_n = h_reg.start_n;
    assign pins.power_down_request = h_reg.pd;
    assign pins.bandgap_powerdown_sel = h_reg.bgpd;
    assign pins.refbuffer_powerdown_sel = h_reg.bufpd;
    assign pins.reset = h_reg.rst;
    // Both low reads continuously while reset is low; either high releases the bus
    assign pins.chip_select_n = h_reg.csn;
    assign pins.read_enable_n = h_reg.rdn;
    assign rdata_o = h_reg.rdata;
endmodule
`default_nettype wire

// file: conv_if.sv
// Pins between the converter control and its host.
`timescale 1ns/1ns
`default_nettype none
interface conv_if;
    logic convert_start_n;
    logic power_down_request;
    logic bandgap_powerdown_sel;
    logic refbuffer_powerdown_sel;
    logic reset;
    logic chip_select_n;
    logic read_enable_n;
    logic busy;
    logic [15:0] data_out;
    logic data_oe;
    logic result_unreliable;

    modport device (
        input convert_start_n, power_down_request, bandgap_powerdown_sel, refbuffer_powerdown_sel,
        input reset, chip_select_n, read_enable_n,
        output busy, data_out, data_oe, result_unreliable
    );
    modport host (
        output convert_start_n, power_down_request, bandgap_powerdown_sel, refbuffer_powerdown_sel,
        output reset, chip_select_n, read_enable_n,
        input busy, data_out, data_oe, result_unreliable
    );
endinterface
`default_nettype wire

// file: conv_pkg.sv
// Constants and types shared by the converter control and its host.
//
// What this block does
// - Start-input falling edge launches a conversion.
// - Running conversion never restarted by start; reset rise aborts it.
// - Start handling ignores chip-select and read-enable.
// - After power-up or power-down exit, discard 128.
// - Host may pulse reset for faster initialization.
// - Core drops to low power after conversion.
// - Readout stays operational during acquisition.
// - Both selects low: bandgap and buffer on.
// - Bandgap select high only: buffer amplifies external.
// - Both selects high: bandgap and buffer off.
// - Host returns start high before limit.
// - Host makes start edges low jitter.
// - Conversion end: code available, busy low.
// - Reset rise aborts, tristates; fall initializes, busy.
package conv_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CONV_TIME_NS = 712;
    localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_TIME_NS = 1000;
    localparam int unsigned INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned START_LOW_MAX_NS = 40;
    localparam int unsigned START_LOW_CYCLES = START_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_NS = 40;
    localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DISCARD_COUNT = 128;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // Reference path modes
    typedef enum logic [1:0] {
        REF_INTERNAL,
        REF_EXT_BUFFERED,
        REF_EXT_DIRECT,
        REF_INVALID
    } ref_mode_t;

    // Host register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_DATA = 4'h2;
    localparam logic [3:0] ADDR_PERIOD = 4'h3;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    // Control field positions
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_PD = 1;
    localparam int unsigned CTRL_BGPD = 2;
    localparam int unsigned CTRL_BUFPD = 3;
    localparam int unsigned CTRL_RESET = 4;
    localparam int unsigned CTRL_AUTO = 5;
    localparam int unsigned CTRL_CSN = 6;
    localparam int unsigned CTRL_RDN = 7;
    localparam logic [31:0] PERIOD_RESET = 32'h00000080;
endpackage

// file: ref_select.sv
// Reference path decode from the two power-down selects.
`timescale 1ns/1ns
`default_nettype none
module ref_select (
    input wire logic bandgap_powerdown_sel_i,
    input wire logic refbuffer_powerdown_sel_i,
    output conv_pkg::ref_mode_t ref_mode_o,
    output logic bandgap_enable_o,
    output logic buffer_enable_o
);
    import conv_pkg::*;
    always_comb begin
        ref_mode_o = REF_INVALID;
        bandgap_enable_o = 1'b0;
        buffer_enable_o = 1'b0;
        case ({bandgap_powerdown_sel_i, refbuffer_powerdown_sel_i})
            2'b00: begin
                ref_mode_o = REF_INTERNAL;
                bandgap_enable_o = 1'b1;
                buffer_enable_o = 1'b1;
            end
            2'b10: begin
                ref_mode_o = REF_EXT_BUFFERED;
                buffer_enable_o = 1'b1;
            end
            2'b11: begin
                ref_mode_o = REF_EXT_DIRECT;
            end
            default: begin
                // Buffer off with bandgap on is undefined; both kept off
                ref_mode_o = REF_INVALID;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: test_adc_conversion_power_control.sv
// Testbench driving the host registers with both ends joined.
`timescale 1ns/1ns
`default_nettype none
module test_adc_conversion_power_control;
    import conv_pkg::*;
    logic clk_sys_i;
    logic rst_b_i;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [15:0] sample;
    logic low_power;
    logic bg_en;
    logic buf_en;
    ref_mode_t mode;
    logic [15:0] count;
    int err_total;
    int checks_done;
    int n;
    logic [3:0] ref_exp [4] = '{4'h3, 4'h5, 4'hC, 4'h8};
    conv_if cif();
    conv_device conv_device_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pins(cif.device), .sample_i(sample),
        .core_low_power_o(low_power), .bandgap_enable_o(bg_en), .buffer_enable_o(buf_en), .ref_mode_o(mode),
        .conv_count_o(count));
    conv_host conv_host_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pins(cif.host), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    conv_asserts conv_asserts_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .convert_start_n(cif.convert_start_n),
        .power_down_request(cif.power_down_request), .bandgap_powerdown_sel(cif.bandgap_powerdown_sel),
        .refbuffer_powerdown_sel(cif.refbuffer_powerdown_sel), .reset(cif.reset), .chip_select_n(cif.chip_select_n),
        .read_enable_n(cif.read_enable_n), .busy(cif.busy), .data_out(cif.data_out), .data_oe(cif.data_oe),
        .result_unreliable(cif.result_unreliable));
    // ***********************
    // Bus tasks
    // ***********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask
    // Bounded wait for busy, then count its high cycles
    task automatic measure(output int len);
        int w;
        len = 0;
        w = 0;
        while (cif.busy !== 1'b1 && w < 40) begin
            @(posedge clk_sys_i);
            #1;
            w++;
        end
        chk(32'(low_power), 32'h0, "core awake");
        while (cif.busy === 1'b1 && len < 300) begin
            @(posedge clk_sys_i);
            #1;
            len++;
        end
    endtask
    task automatic conv(input logic [15:0] s);
        int len;
        @(posedge clk_sys_i);
        sample <= s;
        wr_reg(ADDR_CTRL, 32'h1);
        measure(len);
        chk(32'(len), CONV_CYCLES, "conv length");
        chk(32'(cif.data_out), 32'(s), "code");
        chk(32'(low_power), 32'h1, "core asleep");
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_total++;
        print_verdict();
    end
    // ***********************
    // Scenarios
    // ***********************
    initial begin
        err_total = 0;
        checks_done = 0;
        rst_b_i = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        sample = 16'h0000;
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd_chk(ADDR_STATUS, 32'h2, "status at start");
        rd_chk(ADDR_PERIOD, 32'h80, "period reset");
        wr_reg(4'hF, 32'hFFFFFFFF);
        rd_chk(4'hF, 32'h0, "unmapped");
        chk(32'(cif.data_oe), 32'h1, "readout on");
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CTRL, 32'(i) << 2);
            repeat (3) @(posedge clk_sys_i);
            #1;
            chk(32'({mode, bg_en, buf_en}), 32'(ref_exp[i]), "ref path");
        end
        wr_reg(ADDR_CTRL, 32'h0);
        wr_reg(ADDR_CTRL, 32'hC1);
        measure(n);
        chk(32'(n), CONV_CYCLES, "deselected conv");
        chk(32'(cif.data_oe), 32'h0, "readout off");
        conv(16'hA5C3);
        rd_chk(ADDR_DATA, 32'h0000A5C3, "data reg");
        chk(32'(count), 32'h2, "count");
        fork
            conv(16'h5A3C);
            begin
                repeat (12) @(posedge clk_sys_i);
                rd_chk(ADDR_STATUS, 32'h3, "status busy");
                wr_reg(ADDR_CTRL, 32'h3);
            end
        join
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk(32'(cif.busy), 32'h0, "no queued start");
        chk(32'(count), 32'h3, "count once");
        wr_reg(ADDR_CTRL, 32'h3);
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(32'(cif.busy), 32'h0, "start in power-down");
        wr_reg(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_STATUS, 32'h2, "pd exit");
        for (int i = 0; i < 128; i++) begin
            conv(16'(i * 3 + 7));
            if (i == 126) begin
                rd_chk(ADDR_STATUS, 32'h2, "still unreliable");
            end
        end
        rd_chk(ADDR_STATUS, 32'h0, "reliable");
        conv(16'h1234);
        rd_chk(ADDR_COUNT, 32'h1, "reliable count");
        wr_reg(ADDR_PERIOD, 32'h63);
        n = int'(count);
        wr_reg(ADDR_CTRL, 32'h20);
        rd_chk(ADDR_CTRL, 32'h20, "auto on");
        repeat (393) @(posedge clk_sys_i);
        wr_reg(ADDR_CTRL, 32'h0);
        chk(32'(count), 32'(n + 3), "auto runs");
        rd_chk(ADDR_COUNT, 32'h4, "auto good");
        wr_reg(ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clk_sys_i);
        wr_reg(ADDR_CTRL, 32'h10);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(32'({cif.reset, cif.busy, cif.data_oe}), 32'h4, "abort");
        fork
            measure(n);
            begin
                repeat (30) @(posedge clk_sys_i);
                wr_reg(ADDR_CTRL, 32'h1);
            end
        join
        chk(32'(n), INIT_CYCLES, "init length");
        chk(32'(cif.data_out), 32'h0, "bus cleared");
        rd_chk(ADDR_STATUS, 32'h0, "fast init");
        conv(16'hFFFF);
        rd_chk(ADDR_COUNT, 32'h5, "count after init");
        print_verdict();
    end
endmodule
`default_nettype wire
